// ### csbp_defines.vh
// constants for the card slot bus port: windows, spaces, address split
`ifndef CSBP_DEFINES_VH
`define CSBP_DEFINES_VH
// slot window select, top nibble of the system address
`define CSBP_WIN_MSB 31
`define CSBP_WIN_LSB 28
`define CSBP_SLOT0_WIN 4'h3
`define CSBP_SLOT1_WIN 4'h4
// quarter select inside a slot window
`define CSBP_SPACE_MSB 27
`define CSBP_SPACE_LSB 26
`define CSBP_SPACE_ATTR 2'h0
`define CSBP_SPACE_IO 2'h1
`define CSBP_SPACE_MEM 2'h2
`define CSBP_SPACE_REG 2'h3
// card address split over two address clocks
`define CSBP_AHI_MSB 25
`define CSBP_AHI_LSB 16
`define CSBP_ALO_MSB 15
`define CSBP_ALO_LSB 0
`define CSBP_AHI_PAD 6'h00
// chip enables idle high
`define CSBP_CE_IDLE 2'h3
`endif

// ### csbp_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module csbp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire MCLK_I,
  input wire SYS_RST_I,
  // pin side and synchronised side
  input wire [WIDTH-1:0] ASYNC_I,
  output wire [WIDTH-1:0] SYNC_O
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage is read only by the second
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= ASYNC_I;
      sync_ff <= meta_ff;
    end
  end

  assign SYNC_O = sync_ff;
endmodule // csbp_sync
`default_nettype wire

// ### csbp_card_port.v
// host-side card slot bus port: decode, multiplexed card cycles, dma and lock inputs
`timescale 1ns/1ns
`default_nettype none
`include "csbp_defines.vh"
// Notes on behaviour
// - card cycles multiplex 26-bit address and 16-bit data on one bus half
// - address sent in two clocks: ten bits first, sixteen bits second
// - write data driven in the third chip-enable clock
// - full-word write adds upper data in the fourth clock
// - bus shared; drive card cycles only while the arbiter grants it (grant checked only before the first address clock, not during the cycle)
// - slot windows of 256 MB at 0x30000000 and 0x40000000, own chip enable
// - window quartered: attribute, I/O, common memory, register space
// - active-low card request line paces host dma transfers
// - dma memory-to-memory and I/O-to-memory moves reach card windows alike
// - cards accessed like memory, no separate I/O cycle type
// - slot lock switches read through general pins two and three
module csbp_card_port #(
  parameter LANE_UPPER = 0
) (
  // clock and reset
  input wire MCLK_I,
  input wire SYS_RST_I,
  // access requests from processor or dma
  input wire REQ_VALID_I,
  input wire [31:0] REQ_ADDR_I,
  input wire REQ_WRITE_I,
  input wire REQ_WORD_I,
  input wire REQ_FROM_DMA_I,
  input wire [31:0] REQ_WDATA_I,
  output reg REQ_READY_O,
  // access answers
  output reg RSP_VALID_O,
  output reg RSP_ERR_O,
  output reg RSP_FROM_DMA_O,
  output reg [31:0] RSP_RDATA_O,
  // shared memory bus arbitration
  output reg MEM_BUS_REQ_O,
  input wire MEM_BUS_GNT_I,
  // shared memory data bus pins
  input wire [31:0] MEM_DATA_I,
  output reg [31:0] MEM_DATA_O,
  output reg [1:0] MEM_DATA_OE_O,
  // card controller strobes
  output reg [1:0] CARD_CHIP_ENABLE_N_O,
  output reg [1:0] CARD_SPACE_O,
  input wire [1:0] CARD_DMA_REQUEST_N_I,
  output reg [1:0] DMA_CARD_REQ_O,
  // lock switch pins and their levels
  input wire GENERAL_PIN_TWO_I,
  input wire GENERAL_PIN_THREE_I,
  output reg SLOT0_LOCK_INPUT_O,
  output reg SLOT1_LOCK_INPUT_O
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ARB = 3'h1;
  localparam ST_AHI = 3'h2;
  localparam ST_ALO = 3'h3;
  localparam ST_D1 = 3'h4;
  localparam ST_D2 = 3'h5;
  localparam ST_REL = 3'h6;
  localparam ST_RWAIT = 3'h7;
  localparam LANE_LSB = (LANE_UPPER != 0) ? 16 : 0;
  localparam [1:0] LANE_OE = (LANE_UPPER != 0) ? 2'h2 : 2'h1;

  reg [2:0] state_ff;
  reg [31:0] addr_ff;
  reg [31:0] wdata_ff;
  reg write_ff;
  reg word_ff;
  reg slot_ff;
  reg [1:0] lo_pipe_ff;
  reg [1:0] hi_pipe_ff;
  wire [15:0] rd_sync;
  wire [3:0] pin_sync;
  wire [1:0] dec;

  // returns {hit, slot} for a system address
  function [1:0] slot_decode;
    input [31:0] a;
    begin
      if (a[`CSBP_WIN_MSB:`CSBP_WIN_LSB] == `CSBP_SLOT0_WIN)
        slot_decode = 2'h2;
      else if (a[`CSBP_WIN_MSB:`CSBP_WIN_LSB] == `CSBP_SLOT1_WIN)
        slot_decode = 2'h3;
      else
        slot_decode = 2'h0;
    end
  endfunction

  assign dec = slot_decode(REQ_ADDR_I);

  // read lane, synchronised like any pin; costs two cycles of latency
  csbp_sync #(
    .WIDTH(16),
    .RST_VAL(16'h0000)
  ) u_rd_sync (
    .MCLK_I(MCLK_I),
    .SYS_RST_I(SYS_RST_I),
    .ASYNC_I(MEM_DATA_I[LANE_LSB +: 16]),
    .SYNC_O(rd_sync)
  );

  // card request lines idle high, lock pins idle low
  csbp_sync #(
    .WIDTH(4),
    .RST_VAL(4'hc)
  ) u_pin_sync (
    .MCLK_I(MCLK_I),
    .SYS_RST_I(SYS_RST_I),
    .ASYNC_I({CARD_DMA_REQUEST_N_I, GENERAL_PIN_THREE_I, GENERAL_PIN_TWO_I}),
    .SYNC_O(pin_sync)
  );

  // status levels registered for clean outputs
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DMA_CARD_REQ_O <= 2'h0;
      SLOT0_LOCK_INPUT_O <= 1'b0;
      SLOT1_LOCK_INPUT_O <= 1'b0;
    end else begin
      // request low means card wants service
      DMA_CARD_REQ_O <= ~pin_sync[3:2];
      // lock switches on pins two and three
      SLOT0_LOCK_INPUT_O <= pin_sync[0];
      SLOT1_LOCK_INPUT_O <= pin_sync[1];
    end
  end

  // card cycle sequencer
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_ff <= ST_IDLE;
      addr_ff <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      write_ff <= 1'b0;
      word_ff <= 1'b0;
      slot_ff <= 1'b0;
      lo_pipe_ff <= 2'h0;
      hi_pipe_ff <= 2'h0;
      REQ_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_ERR_O <= 1'b0;
      RSP_FROM_DMA_O <= 1'b0;
      RSP_RDATA_O <= 32'h00000000;
      MEM_BUS_REQ_O <= 1'b0;
      MEM_DATA_O <= 32'h00000000;
      MEM_DATA_OE_O <= 2'h0;
      CARD_CHIP_ENABLE_N_O <= `CSBP_CE_IDLE;
      CARD_SPACE_O <= `CSBP_SPACE_ATTR;
    end else begin
      RSP_VALID_O <= 1'b0;
      // mark read data clocks, seen two cycles later past the synchroniser
      lo_pipe_ff <= {lo_pipe_ff[0], (state_ff == ST_D1) && !write_ff};
      hi_pipe_ff <= {hi_pipe_ff[0], (state_ff == ST_D2) && !write_ff};
      case (state_ff)
        ST_IDLE: begin
          REQ_READY_O <= 1'b1;
          if (REQ_VALID_I && REQ_READY_O) begin
            REQ_READY_O <= 1'b0;
            addr_ff <= REQ_ADDR_I;
            wdata_ff <= REQ_WDATA_I;
            write_ff <= REQ_WRITE_I;
            word_ff <= REQ_WORD_I;
            slot_ff <= dec[0];
            RSP_FROM_DMA_O <= REQ_FROM_DMA_I;
            RSP_ERR_O <= 1'b0;
            RSP_RDATA_O <= 32'h00000000;
            // one memory-style cycle type for every space
            // dma and processor requests take the same path
            if (dec[1]) begin
              // ask the arbiter before touching the bus
              MEM_BUS_REQ_O <= 1'b1;
              state_ff <= ST_ARB;
            end else begin
              // unmapped address answers an error with no card cycle
              RSP_VALID_O <= 1'b1;
              RSP_ERR_O <= 1'b1;
              state_ff <= ST_REL;
            end
          end
        end
        ST_ARB: begin
          // wait for ownership of the shared bus
          if (MEM_BUS_GNT_I) begin
            CARD_CHIP_ENABLE_N_O[slot_ff] <= 1'b0;
            // quarter from the top offset bits
            CARD_SPACE_O <= addr_ff[`CSBP_SPACE_MSB:`CSBP_SPACE_LSB];
            MEM_DATA_O[LANE_LSB +: 16] <=
              {`CSBP_AHI_PAD, addr_ff[`CSBP_AHI_MSB:`CSBP_AHI_LSB]};
            MEM_DATA_OE_O <= LANE_OE;
            state_ff <= ST_AHI;
          end
        end
        ST_AHI: begin
          // second address clock, low sixteen bits
          MEM_DATA_O[LANE_LSB +: 16] <= addr_ff[`CSBP_ALO_MSB:`CSBP_ALO_LSB];
          state_ff <= ST_ALO;
        end
        ST_ALO: begin
          // write data in third clock, reads release the lane
          if (write_ff)
            MEM_DATA_O[LANE_LSB +: 16] <= wdata_ff[15:0];
          else
            MEM_DATA_OE_O <= 2'h0;
          state_ff <= ST_D1;
        end
        ST_D1: begin
          if (word_ff) begin
            // upper half in the fourth clock
            if (write_ff)
              MEM_DATA_O[LANE_LSB +: 16] <= wdata_ff[31:16];
            state_ff <= ST_D2;
          end else begin
            // release enable after the last data clock
            CARD_CHIP_ENABLE_N_O <= `CSBP_CE_IDLE;
            MEM_DATA_OE_O <= 2'h0;
            MEM_BUS_REQ_O <= 1'b0;
            RSP_VALID_O <= write_ff;
            state_ff <= write_ff ? ST_REL : ST_RWAIT;
          end
        end
        ST_D2: begin
          // release enable after the last data clock
          CARD_CHIP_ENABLE_N_O <= `CSBP_CE_IDLE;
          MEM_DATA_OE_O <= 2'h0;
          MEM_BUS_REQ_O <= 1'b0;
          RSP_VALID_O <= write_ff;
          state_ff <= write_ff ? ST_REL : ST_RWAIT;
        end
        ST_RWAIT: begin
          // gather read halves, low then high
          if (lo_pipe_ff[1])
            RSP_RDATA_O[15:0] <= rd_sync;
          if (hi_pipe_ff[1])
            RSP_RDATA_O[31:16] <= rd_sync;
          if (word_ff ? hi_pipe_ff[1] : lo_pipe_ff[1]) begin
            RSP_VALID_O <= 1'b1;
            REQ_READY_O <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_REL: begin
          // one idle clock with enables high before the next access
          REQ_READY_O <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // csbp_card_port
`default_nettype wire

// ### csbp_card_port_props.sv
// assertions on the card slot bus port pins
`timescale 1ns/1ns
`default_nettype none
module csbp_card_port_props #(
  parameter LANE_UPPER = 0
) (
  // clock, reset and request side
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire logic [31:0] REQ_ADDR_I,
  input wire logic REQ_READY_O,
  input wire logic RSP_VALID_O,
  input wire logic RSP_ERR_O,
  // bus and card side
  input wire logic MEM_BUS_REQ_O,
  input wire logic MEM_BUS_GNT_I,
  input wire logic [31:0] MEM_DATA_O,
  input wire logic [1:0] MEM_DATA_OE_O,
  input wire logic [1:0] CARD_CHIP_ENABLE_N_O,
  // pins and their levels
  input wire logic [1:0] CARD_DMA_REQUEST_N_I,
  input wire logic [1:0] DMA_CARD_REQ_O,
  input wire logic GENERAL_PIN_TWO_I,
  input wire logic GENERAL_PIN_THREE_I,
  input wire logic SLOT0_LOCK_INPUT_O,
  input wire logic SLOT1_LOCK_INPUT_O
);
  localparam [1:0] LANE_OE = LANE_UPPER ? 2'b10 : 2'b01;
  // idle while both enables are high; lane is the half that carries card traffic
  wire logic idle = &CARD_CHIP_ENABLE_N_O;
  wire logic [15:0] lane = LANE_UPPER ? MEM_DATA_O[31:16] : MEM_DATA_O[15:0];
  wire logic take = REQ_VALID_I && REQ_READY_O;
  wire logic hit = REQ_ADDR_I[31:28] == 4'h3 || REQ_ADDR_I[31:28] == 4'h4;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_one_slot_enable: assert property (CARD_CHIP_ENABLE_N_O != 2'b00)
    else $error("both slot enables low");
  a_cycle_owns_bus: assert property (!idle |-> MEM_BUS_GNT_I && MEM_BUS_REQ_O)
    else $error("card cycle without bus grant");
  a_hi_addr_pad: assert property ($fell(idle) |-> MEM_DATA_OE_O == LANE_OE && lane[15:10] == 6'h0)
    else $error("first address clock wrong");
  a_lo_addr_driven: assert property ($fell(idle) |=> MEM_DATA_OE_O == LANE_OE)
    else $error("second address clock not driven");
  a_enable_held: assert property ($fell(idle) |=> $stable(CARD_CHIP_ENABLE_N_O)[*2])
    else $error("enable dropped inside access");
  a_enable_gap: assert property ($rose(idle) |=> idle[*2])
    else $error("no idle gap between accesses");
  a_lane_only: assert property (MEM_DATA_OE_O != 2'b00 |-> !idle && MEM_DATA_OE_O == LANE_OE)
    else $error("bus driven outside a card cycle");
  a_unmapped_error: assert property (take && !hit |=> RSP_VALID_O && RSP_ERR_O && idle)
    else $error("unmapped access not refused");
  a_rsp_one_cycle: assert property (RSP_VALID_O |=> !RSP_VALID_O)
    else $error("answer longer than one cycle");
  a_dma_follow: assert property ($stable(CARD_DMA_REQUEST_N_I)[*4] |-> DMA_CARD_REQ_O == ~CARD_DMA_REQUEST_N_I)
    else $error("card request level wrong");
  a_lock_follow: assert property ($stable({GENERAL_PIN_TWO_I, GENERAL_PIN_THREE_I})[*4]
    |-> {SLOT0_LOCK_INPUT_O, SLOT1_LOCK_INPUT_O} == {GENERAL_PIN_TWO_I, GENERAL_PIN_THREE_I})
    else $error("lock level wrong");
endmodule // csbp_card_port_props
bind csbp_card_port csbp_card_port_props #(.LANE_UPPER(LANE_UPPER)) i_props (.*);
`default_nettype wire

// ### csbp_card_model.sv
// behavioural card controller on the lower lane of the shared bus
`timescale 1ns/1ns
`default_nettype none
module csbp_card_model (
  // clock and strobes from the port
  input wire logic clk_i,
  input wire logic [1:0] ce_n_i,
  input wire logic [1:0] space_i,
  input wire logic [31:0] data_i,
  input wire logic [1:0] oe_i,
  // card drive and captured cycle
  output logic [31:0] data_o,
  output logic done_o,
  output logic [61:0] cap_o
);
  int n = 0;
  initial begin
    data_o = 32'h0;
    done_o = 1'b0;
    cap_o = 62'h0;
  end
  // count enable clocks; a released lane toggles so stale data never looks valid
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (&ce_n_i) begin
      done_o <= n > 0;
      n = 0;
    end else begin
      n = n + 1;
      if (n == 1) cap_o = {ce_n_i, space_i, data_i[9:0], 48'h0};
      if (n == 2) cap_o[47:32] = data_i[15:0];
      // write data in third and fourth clocks
      if (n > 2 && n < 5 && oe_i[0]) cap_o[16*(n-3) +: 16] = data_i[15:0];
      // card answers after the address clocks
      if (n == 2) data_o <= {~data_o[31:16], cap_o[47:32]};
      if (n == 3) data_o <= {~data_o[31:16], ~cap_o[47:32]};
    end
  end
endmodule // csbp_card_model
`default_nettype wire

// ### csbp_tb.sv
// self-checking bench for the card slot bus port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic MCLK_I = 1'b0, SYS_RST_I = 1'b1, REQ_VALID_I = 1'b0, REQ_WRITE_I = 1'b0;
  logic REQ_WORD_I = 1'b0, REQ_FROM_DMA_I = 1'b0, MEM_BUS_GNT_I = 1'b0;
  logic GENERAL_PIN_TWO_I = 1'b0, GENERAL_PIN_THREE_I = 1'b0;
  logic [31:0] REQ_ADDR_I = 32'h0, REQ_WDATA_I = 32'h0, MEM_DATA_I, MEM_DATA_O;
  logic [31:0] RSP_RDATA_O, card_data;
  logic [1:0] CARD_DMA_REQUEST_N_I = 2'h3, MEM_DATA_OE_O, CARD_CHIP_ENABLE_N_O;
  logic [1:0] CARD_SPACE_O, DMA_CARD_REQ_O;
  logic REQ_READY_O, RSP_VALID_O, RSP_ERR_O, RSP_FROM_DMA_O, MEM_BUS_REQ_O;
  logic SLOT0_LOCK_INPUT_O, SLOT1_LOCK_INPUT_O, card_done;
  logic [61:0] card_cap, bus_q[$];
  logic [33:0] rsp_q[$];
  integer seed = 32'hca3c, pseed = 32'hca3c, num_errors = 0, total_checks = 0;
  // wire level: the port drives its lane while enabled, else the card's pattern
  assign MEM_DATA_I = {card_data[31:16], MEM_DATA_OE_O[0] ? MEM_DATA_O[15:0] : card_data[15:0]};
  csbp_card_port i_dut (.*);
  csbp_card_model i_card (.clk_i(MCLK_I), .ce_n_i(CARD_CHIP_ENABLE_N_O), .space_i(CARD_SPACE_O),
    .data_i(MEM_DATA_O), .oe_i(MEM_DATA_OE_O), .data_o(card_data), .done_o(card_done),
    .cap_o(card_cap));
  // 125 MHz clock
  initial forever #4 MCLK_I = ~MCLK_I;
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (exp !== got) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access: hold the request until the edge that takes it, note the outcome
  task automatic access(input logic [31:0] a, input logic w, input logic wo, input logic [31:0] d);
    logic hit;
    int i;
    hit = a[31:28] == 4'h3 || a[31:28] == 4'h4;
    @(negedge MCLK_I);
    {REQ_ADDR_I, REQ_WRITE_I, REQ_WORD_I, REQ_WDATA_I, REQ_FROM_DMA_I} = {a, w, wo, d, d[0]};
    REQ_VALID_I = 1'b1;
    rsp_q.push_back({d[0], !hit, hit && !w ? (wo ? {~a[15:0], a[15:0]} : {16'h0, a[15:0]}) : 32'h0});
    if (hit) bus_q.push_back({a[28] ? 2'b10 : 2'b01, a[27:0], !w ? 32'h0 : wo ? d : {16'h0, d[15:0]}});
    // ready is looked at on the falling edge, where it is settled, so the
    // rising edge that follows is the one that takes the request
    i = 0;
    while (REQ_READY_O !== 1'b1 && i < 60) begin
      @(negedge MCLK_I);
      i++;
    end
    if (REQ_READY_O !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    @(negedge MCLK_I);
    REQ_VALID_I = 1'b0;
  endtask
  // late grant held while asked; pins wander at random
  always @(negedge MCLK_I) begin
    MEM_BUS_GNT_I = MEM_BUS_REQ_O && (MEM_BUS_GNT_I || $random(pseed) % 2 == 0);
    if ($random(pseed) % 8 == 0) begin
      {CARD_DMA_REQUEST_N_I, GENERAL_PIN_TWO_I, GENERAL_PIN_THREE_I} = $random(pseed);
    end
  end
  // compare each answer and each card cycle with the oldest note
  always @(negedge MCLK_I) begin
    if (RSP_VALID_O === 1'b1) check("answer", rsp_q.pop_front(), {RSP_FROM_DMA_O, RSP_ERR_O, RSP_RDATA_O});
    if (card_done === 1'b1) check("card cycle", bus_q.pop_front(), card_cap);
  end
  // reset, then every slot, quarter and transfer kind, then every unmapped window
  initial begin
    logic [31:0] a;
    repeat (5) @(posedge MCLK_I);
    @(negedge MCLK_I);
    SYS_RST_I = 1'b0;
    for (int k = 0; k < 32; k++) begin
      a = $random(seed);
      a[31:26] = {k[4] ? 4'h4 : 4'h3, k[1:0]};
      access(a, k[2], k[3], $random(seed));
    end
    for (int j = 0; j < 16; j++) begin
      a = $random(seed);
      a[31:28] = j[3:0];
      if (j != 3 && j != 4) access(a, j[0], j[1], a);
    end
    repeat (20) @(posedge MCLK_I);
    check("notes left", 64'h0, rsp_q.size() + bus_q.size());
    print_verdict();
  end
endmodule // tb
`default_nettype wire
